// ### core/clbd_core.sv
// Execute unit for the short AND, short branch and compact branch forms.
// Assumes the fetch stage offers one instruction at a time with its PC,
// and applies every redirect it is given before the next fetch.
//
// Notes on behaviour
// - Short AND immediate: zero-extended mask AND source
// - Four-bit code selects one of sixteen masks
// - Three-bit selectors reach only eight registers
// - Short register AND writes second source register
// - Unconditional short branch: ten-bit offset, doubled
// - Short branch if zero: seven-bit offset, doubled
// - Delayed branches redirect after the slot instruction
// - Compact branch if zero, no delay slot
`timescale 1ns/1ps
`default_nettype none
module clbd_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction offer
  input wire logic instr_valid,
  input wire clbd_pkg::clbd_instr_type instr_in,
  output logic instr_ready,
  // Register preload, taken only while idle
  input wire logic load_en,
  input wire logic [clbd_pkg::REG_AW-1:0] load_addr,
  input wire logic [clbd_pkg::XLEN-1:0] load_data,
  // Results
  output clbd_pkg::clbd_wb_type wb_out,
  output clbd_pkg::clbd_redirect_type redirect_out,
  output logic done,
  output logic unknown,
  output logic slot_pending
);
  import clbd_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b10
  } clbd_state_type;

  typedef struct packed {
    clbd_state_type state;
    clbd_instr_type instr;
    logic pend;
    logic [XLEN-1:0] pend_target;
    clbd_wb_type wb;
    clbd_redirect_type redirect;
    logic done;
    logic unknown;
  } clbd_core_type;

  clbd_core_type core_reg;
  clbd_core_type core_next;

  logic [REG_AW-1:0] rd_a_addr;
  logic [REG_AW-1:0] rd_b_addr;
  logic [XLEN-1:0] rd_a_data;
  logic [XLEN-1:0] rd_b_data;
  logic wr_en;
  logic [REG_AW-1:0] wr_addr;
  logic [XLEN-1:0] wr_data;

  // ==========================================================
  // Decode of the held instruction
  logic [15:0] half;
  logic [5:0] maj16;
  logic [5:0] maj32;
  logic is_and_imm;
  logic is_reg_and;
  logic is_b16;
  logic is_short_branch_if_zero;
  logic is_compact_branch_if_zero;
  logic [XLEN-1:0] slot_pc;
  logic [XLEN-1:0] off_b16;
  logic [XLEN-1:0] off_short_branch_if_zero;
  logic [XLEN-1:0] off_compact_branch_if_zero;

  always_comb begin
    half = core_reg.instr.word[15:0];
    maj16 = half[MAJ16_LSB +: 6];
    maj32 = core_reg.instr.word[MAJ32_LSB +: 6];
    is_and_imm = !core_reg.instr.wide && (maj16 == OP_AND_IMM);
    is_reg_and = !core_reg.instr.wide && (maj16 == OP_SHORT_MINOR)
      && (half[9:6] == MINOR_REG_AND);
    is_b16 = !core_reg.instr.wide && (maj16 == OP_SHORT_BRANCH);
    is_short_branch_if_zero = !core_reg.instr.wide && (maj16 == OP_SHORT_BEQZ);
    is_compact_branch_if_zero = core_reg.instr.wide && (maj32 == OP_LONG_IMM)
      && (core_reg.instr.word[MIN32_LSB +: 5] == MINOR_COMPACT_BEQZ);
    // The slot instruction follows a short branch at PC plus two
    slot_pc = core_reg.instr.pc + STEP16;
    off_b16 = {{21{half[9]}}, half[9:0], 1'b0};
    off_short_branch_if_zero = {{24{half[6]}}, half[6:0], 1'b0};
    off_compact_branch_if_zero = {{15{half[15]}}, half, 1'b0};
  end

  // ==========================================================
  // Register selection
  always_comb begin
    rd_a_addr = ZERO_REG;
    rd_b_addr = ZERO_REG;
    if (is_and_imm) begin
      rd_a_addr = clbd_reg_map(half[6:4]);
    end else if (is_reg_and) begin
      rd_a_addr = clbd_reg_map(half[2:0]);
      rd_b_addr = clbd_reg_map(half[5:3]);
    end else if (is_short_branch_if_zero) begin
      rd_a_addr = clbd_reg_map(half[9:7]);
    end else if (is_compact_branch_if_zero) begin
      rd_a_addr = core_reg.instr.word[REG32_LSB +: 5];
    end
  end

  // ==========================================================
  // Sequencing and execution
  always_comb begin
    core_next = core_reg;
    core_next.wb.valid = 1'b0;
    core_next.redirect.valid = 1'b0;
    core_next.done = 1'b0;
    core_next.unknown = 1'b0;
    wr_en = 1'b0;
    wr_addr = load_addr;
    wr_data = load_data;
    unique case (core_reg.state)
      ST_IDLE: begin
        if (instr_valid) begin
          core_next.instr = instr_in;
          core_next.state = ST_READ;
        end else if (load_en) begin
          wr_en = 1'b1;
        end
      end
      ST_READ: begin
        core_next.state = ST_EXEC;
      end
      ST_EXEC: begin
        core_next.state = ST_IDLE;
        core_next.done = 1'b1;
        if (is_and_imm) begin
          wr_addr = clbd_reg_map(half[9:7]);
          wr_data = rd_a_data & {16'h0000, clbd_mask(half[3:0])};
          wr_en = 1'b1;
        end else if (is_reg_and) begin
          wr_addr = rd_b_addr;
          wr_data = rd_a_data & rd_b_data;
          wr_en = 1'b1;
        end else if (!(is_b16 || is_short_branch_if_zero || is_compact_branch_if_zero)) begin
          core_next.unknown = 1'b1;
        end
        // Executed results never write register zero
        if (wr_addr == ZERO_REG) begin
          wr_en = 1'b0;
        end
        core_next.wb.valid = wr_en;
        core_next.wb.addr = wr_addr;
        core_next.wb.data = wr_data;
        // A pending target takes effect once the slot has executed
        if (core_reg.pend) begin
          core_next.redirect.valid = 1'b1;
          core_next.redirect.target = core_reg.pend_target;
          core_next.pend = 1'b0;
        end
        // A branch in the slot is undefined; a taken short one rearms, a taken compact one replaces the pending target
        if (is_b16) begin
          core_next.pend = 1'b1;
          core_next.pend_target = slot_pc + off_b16;
        end else if (is_short_branch_if_zero && (rd_a_data == '0)) begin
          core_next.pend = 1'b1;
          core_next.pend_target = slot_pc + off_short_branch_if_zero;
        end else if (is_compact_branch_if_zero && (rd_a_data == '0)) begin
          core_next.redirect.valid = 1'b1;
          core_next.redirect.target = core_reg.instr.pc + STEP32 + off_compact_branch_if_zero;
        end
      end
      default: begin
        core_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reg.state <= ST_IDLE;
      core_reg.instr <= '0;
      core_reg.pend <= 1'b0;
      core_reg.pend_target <= PC_RESET;
      core_reg.wb <= '0;
      core_reg.redirect <= '0;
      core_reg.done <= 1'b0;
      core_reg.unknown <= 1'b0;
    end else begin
      core_reg <= core_next;
    end
  end

  // ==========================================================
  // Storage
  clbd_regfile #(
    .WIDTH(XLEN),
    .AW(REG_AW)
  ) u_regfile (
    .clk(clk),
    .rst_b(rst_b),
    .rd_a_addr(rd_a_addr),
    .rd_b_addr(rd_b_addr),
    .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // ==========================================================
  // Outputs
  assign instr_ready = (core_reg.state == ST_IDLE);
  assign wb_out = core_reg.wb;
  assign redirect_out = core_reg.redirect;
  assign done = core_reg.done;
  assign unknown = core_reg.unknown;
  assign slot_pending = core_reg.pend;

endmodule : clbd_core
`default_nettype wire

// ### common/clbd_pkg.sv
// Constants, types and helpers for the compact logic and branch decoder.
// Assumes one core clock; the instruction word arrives already fetched.
`default_nettype none
package clbd_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned XLEN = 32;
  localparam int unsigned REG_AW = 5;

  // ==========================================================
  // Major and minor codes
  localparam logic [5:0] OP_AND_IMM = 6'h0B;
  localparam logic [5:0] OP_SHORT_MINOR = 6'h11;
  localparam logic [5:0] OP_SHORT_BRANCH = 6'h33;
  localparam logic [5:0] OP_SHORT_BEQZ = 6'h23;
  localparam logic [5:0] OP_LONG_IMM = 6'h10;
  localparam logic [3:0] MINOR_REG_AND = 4'h2;
  localparam logic [4:0] MINOR_COMPACT_BEQZ = 5'h07;

  // ==========================================================
  // Field positions
  localparam int unsigned MAJ16_LSB = 10;
  localparam int unsigned MAJ32_LSB = 26;
  localparam int unsigned MIN32_LSB = 21;
  localparam int unsigned REG32_LSB = 16;

  // ==========================================================
  // Addresses and steps
  localparam logic [XLEN-1:0] STEP16 = 32'h0000_0002;
  localparam logic [XLEN-1:0] STEP32 = 32'h0000_0004;
  localparam logic [XLEN-1:0] PC_RESET = 32'h0000_0000;
  localparam logic [REG_AW-1:0] ZERO_REG = 5'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wide;
    logic [XLEN-1:0] pc;
    logic [XLEN-1:0] word;
  } clbd_instr_type;

  typedef struct packed {
    logic valid;
    logic [REG_AW-1:0] addr;
    logic [XLEN-1:0] data;
  } clbd_wb_type;

  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] target;
  } clbd_redirect_type;

  // ==========================================================
  // Three-bit selector to register number
  function automatic logic [REG_AW-1:0] clbd_reg_map(input logic [2:0] sel);
    clbd_reg_map = (sel < 3'h2) ? {2'h2, sel} : {2'h0, sel};
  endfunction : clbd_reg_map

  // Encoded mask immediate
  function automatic logic [15:0] clbd_mask(input logic [3:0] code);
    unique case (code)
      4'h0: clbd_mask = 16'h0080;
      4'h1: clbd_mask = 16'h0001;
      4'h2: clbd_mask = 16'h0002;
      4'h3: clbd_mask = 16'h0003;
      4'h4: clbd_mask = 16'h0004;
      4'h5: clbd_mask = 16'h0007;
      4'h6: clbd_mask = 16'h0008;
      4'h7: clbd_mask = 16'h000F;
      4'h8: clbd_mask = 16'h0010;
      4'h9: clbd_mask = 16'h001F;
      4'hA: clbd_mask = 16'h0020;
      4'hB: clbd_mask = 16'h003F;
      4'hC: clbd_mask = 16'h0040;
      4'hD: clbd_mask = 16'h00FF;
      4'hE: clbd_mask = 16'h8000;
      4'hF: clbd_mask = 16'hFFFF;
    endcase
  endfunction : clbd_mask

endpackage : clbd_pkg
`default_nettype wire

// ### core/clbd_regfile.sv
// General register storage: two read ports, one write port.
// Read data are registered, so data appear one edge after the address.
`timescale 1ns/1ps
`default_nettype none
module clbd_regfile #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned AW = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Read ports
  input wire logic [AW-1:0] rd_a_addr,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [WIDTH-1:0] rd_a_data,
  output logic [WIDTH-1:0] rd_b_data,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data
);

  typedef struct packed {
    logic [WIDTH-1:0] a;
    logic [WIDTH-1:0] b;
  } clbd_rd_type;

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];
  clbd_rd_type rd_reg;
  clbd_rd_type rd_next;

  // ==========================================================
  // Storage
  // Array holds no reset; software state is undefined until written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ==========================================================
  // Registered read
  always_comb begin
    rd_next.a = mem[rd_a_addr];
    rd_next.b = mem[rd_b_addr];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rd_a_data = rd_reg.a;
  assign rd_b_data = rd_reg.b;

endmodule : clbd_regfile
`default_nettype wire

// ### dv/clbd_chk.sv
// Port checker for the compact logic and branch decoder.
// Assumes one clock, bound to clbd_core by the statement at the foot.
`timescale 1ns/1ps
`default_nettype none
module clbd_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction offer
  input wire logic instr_valid,
  input wire clbd_pkg::clbd_instr_type instr_in,
  input wire logic instr_ready,
  // Results
  input wire clbd_pkg::clbd_wb_type wb_out,
  input wire clbd_pkg::clbd_redirect_type redirect_out,
  input wire logic done,
  input wire logic slot_pending
);
  import clbd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Decode of the offer at the take edge
  logic take, is_andi, is_and, is_b, is_bz, is_bc;
  logic [15:0] h;
  logic [5:0] op;
  logic [4:0] exp_addr_reg;
  logic [31:0] exp_tgt_reg;
  function automatic logic [4:0] sel_reg(input logic [2:0] s);
    return (s < 3'h2) ? {2'h2, s} : {2'h0, s};
  endfunction : sel_reg
  assign take = instr_valid && instr_ready;
  assign h = instr_in.word[15:0];
  assign op = instr_in.wide ? instr_in.word[31:26] : h[15:10];
  assign is_andi = take && !instr_in.wide && op == OP_AND_IMM;
  assign is_and = take && !instr_in.wide && op == OP_SHORT_MINOR &&
                  h[9:6] == MINOR_REG_AND;
  assign is_b = take && !instr_in.wide && op == OP_SHORT_BRANCH;
  assign is_bz = take && !instr_in.wide && op == OP_SHORT_BEQZ;
  assign is_bc = take && instr_in.wide && op == OP_LONG_IMM &&
                 instr_in.word[25:21] == MINOR_COMPACT_BEQZ;
  // Target is kept from the branch itself; a slot take must not touch it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exp_addr_reg <= 5'h00;
      exp_tgt_reg <= 32'h0;
    end else if (take) begin
      exp_addr_reg <= is_and ? sel_reg(h[5:3]) : sel_reg(h[9:7]);
      if (is_b) begin
        exp_tgt_reg <= instr_in.pc + STEP16 + {{21{h[9]}}, h[9:0], 1'b0};
      end else if (is_bz) begin
        exp_tgt_reg <= instr_in.pc + STEP16 + {{24{h[6]}}, h[6:0], 1'b0};
      end else if (is_bc) begin
        exp_tgt_reg <= instr_in.pc + STEP32 + {{15{h[15]}}, h, 1'b0};
      end
    end
  end
  // ==========================================================
  // Properties
  property p_latency;
    take |=> !instr_ready ##1 !instr_ready ##1 (done && instr_ready);
  endproperty
  a_latency: assert property (p_latency)
    else $error("done not three edges after take");
  property p_andi_wb;
    is_andi |-> ##3 (wb_out.valid && wb_out.addr == exp_addr_reg);
  endproperty
  a_andi_wb: assert property (p_andi_wb)
    else $error("immediate AND wrote wrong register");
  property p_and_wb;
    is_and |-> ##3 (wb_out.valid && wb_out.addr == exp_addr_reg);
  endproperty
  a_and_wb: assert property (p_and_wb)
    else $error("register AND wrote wrong register");
  property p_arm;
    is_b |-> ##3 (done && slot_pending && !redirect_out.valid);
  endproperty
  a_arm: assert property (p_arm)
    else $error("branch redirected before its slot");
  property p_bz_quiet;
    is_bz |-> ##3 (done && !redirect_out.valid);
  endproperty
  a_bz_quiet: assert property (p_bz_quiet)
    else $error("short zero branch redirected early");
  property p_target;
    redirect_out.valid |-> redirect_out.target == exp_tgt_reg;
  endproperty
  a_target: assert property (p_target)
    else $error("redirect target wrong");
  property p_slot_go;
    $fell(slot_pending) |-> (done && redirect_out.valid);
  endproperty
  a_slot_go: assert property (p_slot_go)
    else $error("armed branch ended without redirect");
  property p_compact;
    is_bc |-> ##3 (done && !slot_pending);
  endproperty
  a_compact: assert property (p_compact)
    else $error("compact branch armed a slot");
  c_andi: cover property (is_andi ##3 wb_out.valid);
  c_slot: cover property ($fell(slot_pending));
  c_compact: cover property (is_bc ##3 redirect_out.valid);
endmodule : clbd_chk
bind clbd_core clbd_chk i_clbd_chk (.clk(clk), .rst_b(rst_b),
  .instr_valid(instr_valid), .instr_in(instr_in),
  .instr_ready(instr_ready), .wb_out(wb_out),
  .redirect_out(redirect_out), .done(done), .slot_pending(slot_pending));
`default_nettype wire

// ### dv/clbd_fetch_model.sv
// Fetch stage model: offers queued instructions with random gaps.
// Assumes the bench queues no branch inside a delay slot.
`timescale 1ns/1ps
`default_nettype none
module clbd_fetch_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Offer to the decoder
  output logic instr_valid,
  output clbd_pkg::clbd_instr_type instr_in,
  input wire logic instr_ready
);
  import clbd_pkg::*;
  clbd_instr_type q[$];
  int gap = 0;
  logic hit = 1'b0;
  initial begin
    instr_valid = 1'b0;
    instr_in = '0;
  end
  task automatic push(input clbd_instr_type i);
    q.push_back(i);
  endtask : push
  always @(posedge clk) hit <= rst_b && instr_valid && instr_ready;
  // Offer held until a take edge; idle word toggles so it is never reused
  always @(negedge clk) begin
    if (hit || !instr_valid) begin
      if (gap == 0 && q.size() > 0) begin
        instr_valid <= 1'b1;
        instr_in <= q.pop_front();
        gap <= $urandom % 3;
      end else begin
        instr_valid <= 1'b0;
        instr_in <= ~instr_in;
        if (gap > 0) begin
          gap <= gap - 1;
        end
      end
    end
  end
endmodule : clbd_fetch_model
`default_nettype wire

// ### dv/tb.sv
// Bench: random and corner instructions, one checked step at a time.
// Assumes the checker is bound and the fetch model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clbd_pkg::*;
  logic clk, rst_b, instr_valid, instr_ready, load_en, done, unknown;
  logic slot_pending;
  clbd_instr_type instr_in;
  logic [4:0] load_addr;
  logic [31:0] load_data, pc, t, m [32];
  clbd_wb_type wb_out;
  clbd_redirect_type redirect_out;
  int err_count = 0, checks_done = 0;
  logic [15:0] mtab [16] = '{16'h0080, 16'h0001, 16'h0002, 16'h0003,
    16'h0004, 16'h0007, 16'h0008, 16'h000F, 16'h0010, 16'h001F, 16'h0020,
    16'h003F, 16'h0040, 16'h00FF, 16'h8000, 16'hFFFF};
  logic [15:0] ofs [6] = '{16'h01FF, 16'hFE40, 16'h8000, 16'h7FFF,
    16'h0000, 16'h0000};
  clbd_core i_clbd_core (.clk(clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr_in(instr_in),
    .instr_ready(instr_ready), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .wb_out(wb_out), .redirect_out(redirect_out),
    .done(done), .unknown(unknown), .slot_pending(slot_pending));
  clbd_fetch_model i_clbd_fetch_model (.clk(clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr_in(instr_in),
    .instr_ready(instr_ready));
  function automatic logic [4:0] rmap(input logic [2:0] s);
    return s < 3'h2 ? {2'h2, s} : {2'h0, s};
  endfunction : rmap
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic cmp_bit(input string n, input logic e, input logic s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, e, s);
    end
  endtask : cmp_bit
  task automatic cmp_word(input string n, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_word
  // Preload is taken only while idle with no offer standing
  task automatic load(input logic [4:0] a, input logic [31:0] d);
    @(negedge clk);
    load_en = 1'b1;
    load_addr = a;
    load_data = d;
    m[a] = d;
    @(negedge clk);
    load_en = 1'b0;
  endtask : load
  task automatic run(input logic w, input logic [31:0] a, wd,
    input logic wv, input logic [4:0] wa, input logic rv,
    input logic [31:0] tg, input logic u);
    int n;
    i_clbd_fetch_model.push({w, a, wd});
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    cmp_bit("done", 1'b1, done);
    cmp_bit("unknown", u, unknown);
    cmp_bit("wb valid", wv, wb_out.valid);
    if (wv) cmp_word("wb addr", {27'h0, wa}, {27'h0, wb_out.addr});
    if (wv) cmp_word("wb data", m[wa], wb_out.data);
    cmp_bit("redirect", rv, redirect_out.valid);
    if (rv) cmp_word("target", tg, redirect_out.target);
  endtask : run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run is near 300 cycles; over sixty times that means a hang
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    int s, d;
    logic z;
    logic [15:0] o;
    rst_b = 1'b0;
    load_en = 1'b0;
    load_addr = 5'h00;
    load_data = 32'h0;
    pc = 32'h0;
    s = $urandom(98);
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    for (int r = 0; r < 8; r++) load(rmap(r[2:0]), $urandom);
    // ==========================================================
    // Logic forms: all ones source shows each mask exactly
    for (int c = 0; c < 16; c++) begin
      s = $urandom % 8;
      d = $urandom % 8;
      load(rmap(s[2:0]), 32'hFFFF_FFFF);
      m[rmap(d[2:0])] = {16'h0, mtab[c]};
      run(1'b0, pc, {16'h0, OP_AND_IMM, d[2:0], s[2:0], c[3:0]}, 1'b1,
          rmap(d[2:0]), 1'b0, 32'h0, 1'b0);
    end
    repeat (8) begin
      s = $urandom % 8;
      d = $urandom % 8;
      m[rmap(d[2:0])] = m[rmap(d[2:0])] & m[rmap(s[2:0])];
      run(1'b0, pc, {16'h0, OP_SHORT_MINOR, MINOR_REG_AND, d[2:0], s[2:0]},
          1'b1, rmap(d[2:0]), 1'b0, 32'h0, 1'b0);
    end
    run(1'b0, pc, {16'h0, 6'h3F, 10'h000}, 1'b0, 5'h00, 1'b0, 32'h0, 1'b1);
    // ==========================================================
    // Branches; slots always hold a plain AND
    load(5'h10, 32'h0);
    load(5'h11, 32'h0000_0001);
    for (int k = 0; k < 6; k++) begin
      o = k < 4 ? ofs[k] : 16'($urandom);
      z = k[0];
      pc = $urandom & 32'h7FFF_FFFE;
      t = pc + 32'h2 + {{21{o[9]}}, o[9:0], 1'b0};
      run(1'b0, pc, {16'h0, OP_SHORT_BRANCH, o[9:0]}, 1'b0, 5'h00, 1'b0,
          32'h0, 1'b0);
      m[2] = m[2] & m[3];
      run(1'b0, pc + 32'h2, {16'h0, OP_SHORT_MINOR, MINOR_REG_AND, 6'h13},
          1'b1, 5'h02, 1'b1, t, 1'b0);
      t = pc + 32'h2 + {{24{o[6]}}, o[6:0], 1'b0};
      run(1'b0, pc, {16'h0, OP_SHORT_BEQZ, 2'h0, z, o[6:0]}, 1'b0, 5'h00,
          1'b0, 32'h0, 1'b0);
      m[2] = m[2] & m[3];
      run(1'b0, pc + 32'h2, {16'h0, OP_SHORT_MINOR, MINOR_REG_AND, 6'h13},
          1'b1, 5'h02, !z, t, 1'b0);
      t = pc + 32'h4 + {{15{o[15]}}, o, 1'b0};
      run(1'b1, pc, {OP_LONG_IMM, MINOR_COMPACT_BEQZ, 4'h8, z, o}, 1'b0,
          5'h00, !z, t, 1'b0);
      m[2] = m[2] & m[3];
      run(1'b0, pc + 32'h4, {16'h0, OP_SHORT_MINOR, MINOR_REG_AND, 6'h13},
          1'b1, 5'h02, 1'b0, 32'h0, 1'b0);
    end
    final_report();
  end
endmodule : tb
`default_nettype wire
